// *** hw/async_rx_filter_defines.vh ***
// Constants for the asynchronous receive filter and formatter
`ifndef ASYNC_RX_FILTER_DEFINES_VH
`define ASYNC_RX_FILTER_DEFINES_VH
// Destination offset windows, low 28 bits, upper offset bits all ones
`define REG_SPACE_LO 28'hf000000
`define REG_SPACE_HI 28'hf0001ff
`define BUS_SPACE_LO 28'hf000200
`define BUS_SPACE_HI 28'hf0003ff
`define CFG_SPACE_LO 28'hf000400
`define CFG_SPACE_HI 28'hf0007ff
`define UNIT_SPACE_LO 28'hf000800
`define UNIT_SPACE_HI 28'hfffffff
`define OFFSET_TOP_ONES 20'hfffff
`define BROADCAST_NODE 6'h3f
// Filter register field positions
`define SRC_MASK_MSB 31
`define SRC_MASK_LSB 16
`define SRC_VALUE_MSB 15
`define SRC_VALUE_LSB 0
// Token field positions
`define TOK_SIZE_LSB 16
`define TOK_SELFID_BIT 15
`define TOK_PHY_BIT 14
`define TOK_ACK_LSB 8
`define TOK_PAD_LSB 6
`define TOK_SPD_LSB 4
// Quadlet transaction codes; only write request and read response carry a data quadlet
`define TCODE_WRQ 4'h0
`define TCODE_RDQ_RESP 4'h6
`define TCODE_RDQ 4'h4
`define TCODE_WR_RESP 4'h2
`endif

// *** hw/rx_word_store.v ***
// Small register-read memory holding formatted quadlets for the application
`timescale 1ns/10ps
module rx_word_store #(
  parameter DEPTH_LOG2 = 3
) (
  input wire core_clk,
  input wire writeEn,
  input wire [DEPTH_LOG2-1:0] writeAddr,
  input wire [31:0] writeData,
  input wire [DEPTH_LOG2-1:0] readAddr,
  output reg [31:0] readData
);
  reg [31:0] mem [0:(1<<DEPTH_LOG2)-1];
  // Write port and registered read port
  always @(posedge core_clk) begin
    if (writeEn) begin
      mem[writeAddr] <= writeData;
    end
    readData <= mem[readAddr];
  end
endmodule // rx_word_store

// *** hw/async_rx_filter_formatter.v ***
// Acceptance filter and quadlet-receive formatter for asynchronous packets
`timescale 1ns/10ps
`include "async_rx_filter_defines.vh"
module async_rx_filter_formatter #(
  parameter NBUF = 4,
  parameter DEPTH_LOG2 = 3
) (
  input wire core_clk,
  input wire srst,
  // Packet from the link receiver, same clock, one-cycle strobe
  input wire pktValid,
  input wire [31:0] hdrQ0,
  input wire [31:0] hdrQ1,
  input wire [31:0] hdrQ2,
  input wire [31:0] dataQ,
  input wire isPhyPkt,
  input wire isSelfIdPkt,
  input wire [4:0] ackCode,
  input wire [1:0] spdCode,
  // Per-buffer controls, one bit per buffer except the two filter words, 32 bits per buffer
  input wire [NBUF-1:0] bufAsyncEn,
  input wire [NBUF-1:0] registerSpaceAccept,
  input wire [NBUF-1:0] busSpaceAccept,
  input wire [NBUF-1:0] cfgSpaceAccept,
  input wire [NBUF-1:0] unitSpaceAccept,
  input wire [NBUF-1:0] tokenInsertEn,
  input wire [NBUF-1:0] dropHeaderQ0,
  input wire [NBUF-1:0] dropHeaderQ1,
  input wire [NBUF-1:0] dropHeaderQ2,
  input wire [NBUF-1:0] dropHeaderQ3,
  input wire [NBUF-1:0] srcFilterEn,
  input wire [NBUF*32-1:0] rxBufferFilterA,
  input wire [NBUF-1:0] hdrFilterEn,
  input wire [NBUF*32-1:0] rxBufferFilterB,
  // Formatted output and memory readback
  input wire [DEPTH_LOG2-1:0] readAddr,
  output reg [31:0] readData,
  output reg pktAccepted,
  output reg pktDropped,
  output reg [NBUF-1:0] acceptBuf,
  output reg [DEPTH_LOG2:0] wordCount,
  output reg busy
);
  // ****************************************
  // Packet decode
  // ****************************************
  wire [15:0] destId = hdrQ0[31:16];
  wire [3:0] tcode = hdrQ0[7:4];
  wire [15:0] srcId = hdrQ1[31:16];
  wire [47:0] destOffset = {hdrQ1[15:0], hdrQ2};
  wire offTop = (destOffset[47:28] == `OFFSET_TOP_ONES);
  wire [27:0] offLow = destOffset[27:0];
  // Only ordinary addressed asynchronous packets reach space matching
  wire plainAsync = !isPhyPkt && !isSelfIdPkt && (destId[5:0] != `BROADCAST_NODE);
  wire inReg = offTop && offLow >= `REG_SPACE_LO && offLow <= `REG_SPACE_HI;
  wire inBus = offTop && offLow >= `BUS_SPACE_LO && offLow <= `BUS_SPACE_HI;
  wire inCfg = offTop && offLow >= `CFG_SPACE_LO && offLow <= `CFG_SPACE_HI;
  wire inUnit = offTop && offLow >= `UNIT_SPACE_LO && offLow <= `UNIT_SPACE_HI;
  // Data quadlet present for quadlet write request and read response
  wire hasData = (tcode == `TCODE_WRQ) || (tcode == `TCODE_RDQ_RESP);

  // ****************************************
  // Per-buffer match
  // ****************************************
  wire [NBUF-1:0] bufMatch;
  genvar g;
  generate
    for (g = 0; g < NBUF; g = g + 1) begin : gMatch
      wire [31:0] fa = rxBufferFilterA[g*32 +: 32];
      wire [31:0] fb = rxBufferFilterB[g*32 +: 32];
      wire [15:0] sMask = fa[`SRC_MASK_MSB:`SRC_MASK_LSB];
      wire [15:0] sVal = fa[`SRC_VALUE_MSB:`SRC_VALUE_LSB];
      wire srcOk = !srcFilterEn[g] || ((srcId & sMask) == (sVal & sMask));
      // Second filter compares masked header quadlet 0 (upper mask, lower value)
      wire hdrOk = !hdrFilterEn[g] ||
        ((hdrQ0[15:0] & fb[31:16]) == (fb[15:0] & fb[31:16]));
      wire spaceOk = (registerSpaceAccept[g] && inReg) || (busSpaceAccept[g] && inBus) ||
        (cfgSpaceAccept[g] && inCfg) || (unitSpaceAccept[g] && inUnit);
      assign bufMatch[g] = bufAsyncEn[g] && plainAsync && spaceOk && srcOk && hdrOk;
    end
  endgenerate

  // Lowest-numbered match wins
  reg [NBUF-1:0] winner;
  integer i;
  always @* begin
    winner = {NBUF{1'b0}};
    for (i = NBUF - 1; i >= 0; i = i - 1) begin
      if (bufMatch[i]) begin
        winner = {NBUF{1'b0}};
        winner[i] = 1'b1;
      end
    end
  end

  // Options of the winning buffer
  wire selToken = |(winner & tokenInsertEn);
  wire selDrop0 = |(winner & dropHeaderQ0);
  wire selDrop1 = |(winner & dropHeaderQ1);
  wire selDrop2 = |(winner & dropHeaderQ2);
  wire selDrop3 = |(winner & dropHeaderQ3);

  // ****************************************
  // Formatter sequence
  // ****************************************
  localparam ST_IDLE = 3'h0;
  localparam ST_TOK = 3'h1;
  localparam ST_H0 = 3'h2;
  localparam ST_H1 = 3'h3;
  localparam ST_H2 = 3'h4;
  localparam ST_DATA = 3'h5;
  localparam ST_DONE = 3'h6;

  reg [2:0] state_reg;
  reg [31:0] q0_reg, q1_reg, q2_reg, d_reg;
  reg tok_reg, dr0_reg, dr1_reg, dr2_reg, dr3_reg, data_reg;
  reg [31:0] token_reg;
  reg [DEPTH_LOG2:0] wptr_reg;
  reg memWe;
  reg [31:0] memWd;
  wire [31:0] memRd;

  // Token: size, S, P, ack, pad (zero for quadlet data), speed passed as coded
  wire [13:0] sizeQ = hasData ? 14'h0004 : 14'h0003;
  wire [31:0] tokenWord = ({18'h00000, sizeQ} << `TOK_SIZE_LSB) |
    ({31'h00000000, isSelfIdPkt} << `TOK_SELFID_BIT) |
    ({31'h00000000, isPhyPkt} << `TOK_PHY_BIT) |
    ({27'h0000000, ackCode} << `TOK_ACK_LSB) |
    ({30'h00000000, spdCode} << `TOK_SPD_LSB);

  // Write strobe per state; drop bits 0 to 2 suppress quadlets, not states
  always @* begin
    memWe = 1'b0;
    memWd = 32'h00000000;
    case (state_reg)
      ST_TOK: begin
        memWe = tok_reg;
        memWd = token_reg;
      end
      ST_H0: begin
        memWe = !dr0_reg;
        memWd = q0_reg;
      end
      ST_H1: begin
        memWe = !dr1_reg;
        memWd = q1_reg;
      end
      ST_H2: begin
        memWe = !dr2_reg;
        memWd = q2_reg;
      end
      ST_DATA: begin
        // Quadlet packets have no length quadlet, so drop bit 3 is moot here
        memWe = data_reg;
        memWd = d_reg;
      end
      default: begin
        memWe = 1'b0;
      end
    endcase
  end

  // Sequencer; new packets are ignored while busy, the link must wait
  always @(posedge core_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      wptr_reg <= {(DEPTH_LOG2+1){1'b0}};
      pktAccepted <= 1'b0;
      pktDropped <= 1'b0;
      acceptBuf <= {NBUF{1'b0}};
      wordCount <= {(DEPTH_LOG2+1){1'b0}};
      busy <= 1'b0;
      q0_reg <= 32'h00000000;
      q1_reg <= 32'h00000000;
      q2_reg <= 32'h00000000;
      d_reg <= 32'h00000000;
      token_reg <= 32'h00000000;
      tok_reg <= 1'b0;
      dr0_reg <= 1'b0;
      dr1_reg <= 1'b0;
      dr2_reg <= 1'b0;
      dr3_reg <= 1'b0;
      data_reg <= 1'b0;
    end else begin
      pktAccepted <= 1'b0;
      pktDropped <= 1'b0;
      if (memWe) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      case (state_reg)
        ST_IDLE: begin
          if (pktValid) begin
            if (|winner) begin
              state_reg <= ST_TOK;
              busy <= 1'b1;
              acceptBuf <= winner;
              wptr_reg <= {(DEPTH_LOG2+1){1'b0}};
              q0_reg <= hdrQ0;
              q1_reg <= hdrQ1;
              q2_reg <= hdrQ2;
              d_reg <= dataQ;
              token_reg <= tokenWord;
              tok_reg <= selToken;
              dr0_reg <= selDrop0;
              dr1_reg <= selDrop1;
              dr2_reg <= selDrop2;
              dr3_reg <= selDrop3;
              data_reg <= hasData;
            end else begin
              pktDropped <= 1'b1;
            end
          end
        end
        ST_TOK: state_reg <= ST_H0;
        ST_H0: state_reg <= ST_H1;
        ST_H1: state_reg <= ST_H2;
        ST_H2: state_reg <= ST_DATA;
        ST_DATA: state_reg <= ST_DONE;
        ST_DONE: begin
          state_reg <= ST_IDLE;
          busy <= 1'b0;
          pktAccepted <= 1'b1;
          wordCount <= wptr_reg;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Output data registered once more so the port comes straight from a flop
  always @(posedge core_clk) begin
    if (srst) begin
      readData <= 32'h00000000;
    end else begin
      readData <= memRd;
    end
  end

  rx_word_store #(
    .DEPTH_LOG2(DEPTH_LOG2)
  ) uStore (
    .core_clk(core_clk),
    .writeEn(memWe),
    .writeAddr(wptr_reg[DEPTH_LOG2-1:0]),
    .writeData(memWd),
    .readAddr(readAddr),
    .readData(memRd)
  );
endmodule // async_rx_filter_formatter

// *** testbench/async_rx_filter_formatter_properties.sv ***
// Checker for packet take, drop and accept timing of the receive filter
`timescale 1ns/10ps
module async_rx_filter_formatter_properties #(
  parameter NBUF = 4,
  parameter DEPTH_LOG2 = 3
) (
  input wire core_clk,
  input wire srst,
  input wire pktValid,
  input wire [31:0] hdrQ0,
  input wire isPhyPkt,
  input wire isSelfIdPkt,
  input wire [NBUF-1:0] bufAsyncEn,
  input wire pktAccepted,
  input wire pktDropped,
  input wire [NBUF-1:0] acceptBuf,
  input wire [DEPTH_LOG2:0] wordCount,
  input wire busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // Busy spans five write cycles plus the closing cycle that raises the accept pulse
  a_accept_latency:
    assert property ($rose(busy) |-> ##6 pktAccepted) else $error("accept late");
  a_busy_holds:
    assert property ($rose(busy) |-> busy[*6] ##1 !busy) else $error("busy length");
  a_busy_cause:
    assert property ($rose(busy) |-> $past(pktValid)) else $error("busy without packet");
  a_phy_refused:
    assert property (pktValid && !busy && (isPhyPkt || isSelfIdPkt) |=> pktDropped)
      else $error("phy or self-id taken");
  a_bcast_refused:
    assert property (pktValid && !busy && hdrQ0[21:16] == 6'h3f |=> pktDropped)
      else $error("broadcast taken");
  a_drop_cause:
    assert property (pktDropped |-> $past(pktValid) && !$past(busy) && !busy)
      else $error("drop without packet");
  a_one_winner:
    assert property (pktAccepted |-> $onehot(acceptBuf)) else $error("winner not one-hot");
  a_enabled_only:
    assert property (pktAccepted |-> (acceptBuf & ~bufAsyncEn) == '0)
      else $error("disabled buffer won");
  a_count_bound:
    assert property (pktAccepted |-> wordCount <= 5) else $error("too many words");
endmodule // async_rx_filter_formatter_properties
bind async_rx_filter_formatter async_rx_filter_formatter_properties #(
  .NBUF(NBUF), .DEPTH_LOG2(DEPTH_LOG2)) u_props (.core_clk, .srst, .pktValid, .hdrQ0,
  .isPhyPkt, .isSelfIdPkt, .bufAsyncEn, .pktAccepted, .pktDropped, .acceptBuf, .wordCount,
  .busy);

// *** testbench/link_rx_model.sv ***
// Link receiver model presenting one received packet per call
`timescale 1ns/10ps
module link_rx_model (
  input wire core_clk,
  output reg pktValid,
  output reg [31:0] hdrQ0,
  output reg [31:0] hdrQ1,
  output reg [31:0] hdrQ2,
  output reg [31:0] dataQ,
  output reg isPhyPkt,
  output reg isSelfIdPkt,
  output reg [4:0] ackCode,
  output reg [1:0] spdCode
);
  // Idle state at time zero
  initial begin
    pktValid = 1'b0;
    {hdrQ0, hdrQ1, hdrQ2, dataQ, isPhyPkt, isSelfIdPkt, ackCode, spdCode} = 137'h0;
  end
  // One-cycle strobe; fields invert afterwards so stale values never look valid
  task send(input [127:0] q, input [8:0] f);
    begin
      @(negedge core_clk);
      {hdrQ0, hdrQ1, hdrQ2, dataQ, isPhyPkt, isSelfIdPkt, ackCode, spdCode} = {q, f};
      pktValid = 1'b1;
      @(negedge core_clk);
      pktValid = 1'b0;
      {hdrQ0, hdrQ1, hdrQ2, dataQ, isPhyPkt, isSelfIdPkt, ackCode, spdCode} = ~{q, f};
    end
  endtask
endmodule // link_rx_model

// *** testbench/async_rx_filter_formatter_bench.sv ***
// Random and corner-case bench for the asynchronous receive filter
`timescale 1ns/10ps
`include "async_rx_filter_defines.vh"
`define CHK(nm, ex, got) begin numChecks = numChecks + 1; if ((got) !== (ex)) begin \
  errors = errors + 1; $display("Error %s expected %h seen %h", nm, ex, got); end end
module async_rx_filter_formatter_bench;
  reg core_clk = 1'b0;
  reg srst = 1'b1;
  reg [3:0] bufAsyncEn, registerSpaceAccept, busSpaceAccept, cfgSpaceAccept, unitSpaceAccept;
  reg [3:0] tokenInsertEn, dropHeaderQ0, dropHeaderQ1, dropHeaderQ2, dropHeaderQ3;
  reg [3:0] srcFilterEn, hdrFilterEn;
  reg [127:0] rxBufferFilterA, rxBufferFilterB;
  reg [2:0] readAddr = 3'h0;
  reg [31:0] q0, q1, q2, d, ex [0:4];
  reg [8:0] f;
  reg [3:0] tc;
  integer seed = 84, errors = 0, numChecks = 0, cyc = 0, i, k, t, w, n;
  wire pktValid, isPhyPkt, isSelfIdPkt, pktAccepted, pktDropped, busy;
  wire [31:0] hdrQ0, hdrQ1, hdrQ2, dataQ, readData;
  wire [4:0] ackCode;
  wire [1:0] spdCode;
  wire [3:0] acceptBuf, wordCount;
  wire [27:0] offLow = q2[27:0];
  link_rx_model u_link_rx_model (.core_clk, .pktValid, .hdrQ0, .hdrQ1, .hdrQ2, .dataQ,
    .isPhyPkt, .isSelfIdPkt, .ackCode, .spdCode);
  async_rx_filter_formatter u_async_rx_filter_formatter (.core_clk, .srst, .pktValid, .hdrQ0,
    .hdrQ1, .hdrQ2, .dataQ, .isPhyPkt, .isSelfIdPkt, .ackCode, .spdCode, .bufAsyncEn,
    .registerSpaceAccept, .busSpaceAccept, .cfgSpaceAccept, .unitSpaceAccept, .tokenInsertEn,
    .dropHeaderQ0, .dropHeaderQ1, .dropHeaderQ2, .dropHeaderQ3, .srcFilterEn, .rxBufferFilterA,
    .hdrFilterEn, .rxBufferFilterB, .readAddr, .readData, .pktAccepted, .pktDropped,
    .acceptBuf, .wordCount, .busy);
  // Clock and hang guard; 40 packets need well under 3000 cycles
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      errors = errors + 1;
      report_and_stop;
    end
  end
  function ok(input [27:0] a, input [27:0] z);
    ok = offLow >= a && offLow <= z;
  endfunction
  // Masked equality; cleared mask bits never block a packet
  function pass(input [31:0] r, input [15:0] v);
    pass = ((v ^ r[15:0]) & r[31:16]) == 16'h0;
  endfunction
  function [127:0] r128();
    r128 = {$random(seed), $random(seed), $random(seed), $random(seed)};
  endfunction
  // Walk buffers downward so the lowest matching one is the last written
  function integer winner();
    integer b;
    begin
      winner = 4;
      for (b = 3; b >= 0; b = b - 1) begin
        if (bufAsyncEn[b] && q1[15:0] == 16'hffff && q2[31:28] == 4'hf && f[8:7] == 2'h0 &&
          q0[21:16] != `BROADCAST_NODE && (!srcFilterEn[b] ||
          pass(rxBufferFilterA[b*32 +: 32], q1[31:16])) && (!hdrFilterEn[b] ||
          pass(rxBufferFilterB[b*32 +: 32], q0[15:0])) && (registerSpaceAccept[b] &&
          ok(`REG_SPACE_LO, `REG_SPACE_HI) || busSpaceAccept[b] && ok(`BUS_SPACE_LO,
          `BUS_SPACE_HI) || cfgSpaceAccept[b] && ok(`CFG_SPACE_LO, `CFG_SPACE_HI) ||
          unitSpaceAccept[b] && ok(`UNIT_SPACE_LO, `UNIT_SPACE_HI)))
          winner = b;
      end
    end
  endfunction
  // Filters are programmed while idle, before the packet they select
  task cfg;
    begin
      {bufAsyncEn, registerSpaceAccept, busSpaceAccept, cfgSpaceAccept} = 16'($random(seed));
      {unitSpaceAccept, tokenInsertEn, dropHeaderQ0, dropHeaderQ1} = 16'($random(seed));
      {dropHeaderQ2, dropHeaderQ3, srcFilterEn, hdrFilterEn} = 16'($random(seed));
      rxBufferFilterA = {4{32'hfffc0000}} | (r128() & {4{32'h00030003}});
      rxBufferFilterB = {4{32'hff0f0000}} | (r128() & {4{32'h00f000f0}});
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", numChecks, errors);
      if (errors == 0 && numChecks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // ************
  // Main sequence
  // ************
  initial begin
    cfg;
    q2 = 32'h0;
    repeat (12) @(negedge core_clk);
    srst = 1'b0;
    for (i = 0; i < 40; i = i + 1) begin
      cfg;
      tc = {`TCODE_WRQ, `TCODE_RDQ_RESP, `TCODE_RDQ, `TCODE_WR_RESP} >> (4 * (i % 4));
      q0 = {10'h0, (i == 10) ? 6'h3f : 6'($random(seed)), 8'h0, tc, 4'h0};
      q1 = {14'h0, 2'($random(seed)), (i % 7 == 3) ? 16'h7fff : 16'hffff};
      q2 = {(i % 9 == 5) ? 4'he : 4'hf, (i < 8) ? 28'({`REG_SPACE_LO, `REG_SPACE_HI,
        `BUS_SPACE_LO, `BUS_SPACE_HI, `CFG_SPACE_LO, `CFG_SPACE_HI, `UNIT_SPACE_LO,
        `UNIT_SPACE_HI} >> (28 * i)) : {4'hf, 24'($random(seed))}};
      d = $random(seed);
      f = {i == 8, i == 9, 7'($random(seed))};
      w = winner();
      n = 0;
      if (w < 4) begin
        ex[0] = {2'h0, 14'd3 + (tc == 4'h0 || tc == 4'h6), 3'h0, f[6:2], 2'h0, f[1:0], 4'h0};
        n = tokenInsertEn[w];
        ex[n] = q0;
        n = n + !dropHeaderQ0[w];
        ex[n] = q1;
        n = n + !dropHeaderQ1[w];
        ex[n] = q2;
        n = n + !dropHeaderQ2[w];
        ex[n] = d;
        n = n + (tc == 4'h0 || tc == 4'h6);
      end
      u_link_rx_model.send({q0, q1, q2, d}, f);
      t = 0;
      if (w < 4 && i % 5 == 1) begin
        u_link_rx_model.send(~{q0, q1, q2, d}, f);
        t = 2;
      end
      `CHK("busy", w < 4, busy)
      while (pktDropped !== 1'b1 && pktAccepted !== 1'b1 && t < 10) begin
        @(negedge core_clk);
        t = t + 1;
      end
      `CHK("cycles", (w == 4) ? 0 : 6, t)
      `CHK("dropped", w == 4, pktDropped)
      if (w < 4) begin
        `CHK("buffer", 4'h1 << w, acceptBuf)
        `CHK("count", n, wordCount)
        for (k = 0; k < n; k = k + 1) begin
          readAddr = k[2:0];
          repeat (3) @(negedge core_clk);
          `CHK("word", ex[k], readData)
        end
      end
      $display("test %0d done", i);
    end
    report_and_stop;
  end
endmodule // async_rx_filter_formatter_bench
